// ### rtl/pmw_defines.svh
// Register offsets, field positions, reset values and key codes of the power/watchdog block
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH

`define PMW_OFF_SYSCLK     8'h00
`define PMW_OFF_FASTRC     8'h04
`define PMW_OFF_WDCTRL     8'h08
`define PMW_OFF_STATUS     8'h0C
`define PMW_OFF_RSTCAUSE   8'h10
`define PMW_OFF_WAKEEN     8'h14

`define PMW_SYSCLK_RST     6'h00
`define PMW_FASTRC_RST     1'b1
`define PMW_WDCTRL_RST     8'h53
`define PMW_WAKEEN_RST     8'h00

`define PMW_DIV_LSB        5
`define PMW_SUBSEL_BIT     2
`define PMW_FASTKEEP_BIT   1
`define PMW_SLOWKEEP_BIT   0
`define PMW_FASTEN_BIT     0
`define PMW_FASTSTB_BIT    1
`define PMW_PDF_BIT        0
`define PMW_TO_BIT         1
`define PMW_WRF_BIT        0

`define PMW_DIV_SUB        3'h7
`define PMW_KEY_ON_A       5'h0A
`define PMW_KEY_ON_B       5'h15
`define PMW_SRESET_CYCLES  16

`endif

// ### rtl/pmw_pkg.sv
// Types shared by the power-mode and watchdog block
package pmw_pkg;

    typedef enum logic [2:0] {
        PMW_FAST,
        PMW_SLOW,
        PMW_SLEEP,
        PMW_IDLE_SLOW,
        PMW_IDLE_BOTH,
        PMW_IDLE_FAST
    } pmw_mode_t;

    typedef struct packed {
        logic [2:0] div;
        logic       subSel;
        logic       fastKeep;
        logic       slowKeep;
    } pmw_sysclk_t;

    typedef struct packed {
        logic [4:0] key;
        logic [2:0] period;
    } pmw_wdctrl_t;

endpackage

// ### rtl/pmw_power_mode_watchdog.sv
// Power mode sequencer, system clock selection and watchdog with APB registers
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pmw_defines.svh"

module pmw_power_mode_watchdog #(
    parameter int NP            = 8,
    parameter int NI            = 4,
    parameter int SRESET_CYCLES = `PMW_SRESET_CYCLES
) (
    input  wire logic            clock,
    input  wire logic            srst,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            haltReq,
    input  wire logic            clrWdtReq,
    input  wire logic [NI-1:0]   intPending,
    input  wire logic            intEnabled,
    input  wire logic            stackFull,
    input  wire logic [NP-1:0]   portA,
    input  wire logic            lircClk,
    input  wire logic            subClk,
    input  wire logic            fastRcStable,
    input  wire logic            subXtalStable,
    input  wire logic            subRcStable,
    output logic                 cpuRun,
    output logic                 ioHold,
    output logic                 sysTick,
    output logic                 sysClkFromSub,
    output logic                 fastOscEn,
    output logic                 subOscEn,
    output pmw_pkg::pmw_mode_t   opMode,
    output logic                 wakeResume,
    output logic                 wakeService,
    output logic                 pcSpReset,
    output logic                 deviceReset
);

    localparam int SW = NP + 5;

    // Pin and foreign-clock inputs pass two flops before use
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic [NP-1:0] portNow;
    logic          lircNow;
    logic          subNow;
    logic          fastStable;
    logic          xtalStable;
    logic          rcStable;

    always_ff @(posedge clock) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {portA, lircClk, subClk, fastRcStable, subXtalStable, subRcStable};
            sync_q <= meta_q;
        end
    end

    assign {portNow, lircNow, subNow, fastStable, xtalStable, rcStable} = sync_q;

    pmw_pkg::pmw_sysclk_t sysClk_q, sysClk_d;
    pmw_pkg::pmw_wdctrl_t wdCtrl_q, wdCtrl_d;
    pmw_pkg::pmw_mode_t   mode_q, mode_d;
    logic          fastRcEn_q, fastRcEn_d;
    logic          pdf_q, pdf_d;
    logic          to_q, to_d;
    logic          wrf_q, wrf_d;
    logic [NP-1:0] wakeEn_q, wakeEn_d;
    logic [NP-1:0] portPrev_q;
    logic          rcPrev_q;
    logic          subPrev_q;
    logic          subActive_q, subActive_d;
    logic          keepFast_q, keepFast_d;
    logic          keepSlow_q, keepSlow_d;
    logic [NI-1:0] intBlock_q, intBlock_d;
    logic [5:0]    divCnt_q, divCnt_d;
    logic [15:0]   srstCnt_q, srstCnt_d;
    logic          cpuRun_q, cpuRun_d;
    logic          ioHold_q, ioHold_d;
    logic          sysTick_q, sysTick_d;
    logic          fastOscEn_q, fastOscEn_d;
    logic          subOscEn_q, subOscEn_d;
    logic          wakeResume_q, wakeResume_d;
    logic          wakeService_q, wakeService_d;
    logic          pcSpReset_q, pcSpReset_d;
    logic          deviceReset_q, deviceReset_d;
    logic [31:0]   prdata_q, prdata_d;
    logic          pready_q, pready_d;
    logic          pslverr_q, pslverr_d;

    logic          rcTick;
    logic          subTick;
    logic          wdClear;
    logic          wdOvf;
    logic          keyOk;
    logic          subReady;
    logic          pinWake;
    logic          intWake;
    logic          hit;
    logic          wrEn;
    logic [31:0]   rdata;
    logic [5:0]    divMask;

    assign rcTick   = lircNow & ~rcPrev_q;
    assign subTick  = subNow & ~subPrev_q;
    assign keyOk    = (wdCtrl_q.key == `PMW_KEY_ON_A) || (wdCtrl_q.key == `PMW_KEY_ON_B);
    assign subReady = sysClk_q.subSel ? xtalStable : rcStable;
    assign pinWake  = |(wakeEn_q & portPrev_q & ~portNow);
    assign intWake  = |(intPending & ~intBlock_q);
    assign divMask  = ~(6'h3F << sysClk_q.div);

    pmw_watchdog #(
        .CW        (18)
    ) uWatchdog (
        .clock     (clock),
        .srst      (srst),
        .rcTick    (rcTick),
        .enable    (keyOk),
        .clear     (wdClear),
        .periodSel (wdCtrl_q.period),
        .overflow  (wdOvf)
    );

    // Register read mux and address decode
    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            `PMW_OFF_SYSCLK: begin
                rdata[7:`PMW_DIV_LSB]    = sysClk_q.div;
                rdata[`PMW_SUBSEL_BIT]   = sysClk_q.subSel;
                rdata[`PMW_FASTKEEP_BIT] = sysClk_q.fastKeep;
                rdata[`PMW_SLOWKEEP_BIT] = sysClk_q.slowKeep;
            end
            `PMW_OFF_FASTRC: begin
                rdata[`PMW_FASTEN_BIT]  = fastRcEn_q;
                rdata[`PMW_FASTSTB_BIT] = fastStable;
            end
            `PMW_OFF_WDCTRL:   rdata[7:0] = wdCtrl_q;
            `PMW_OFF_STATUS: begin
                rdata[`PMW_PDF_BIT] = pdf_q;
                rdata[`PMW_TO_BIT]  = to_q;
            end
            `PMW_OFF_RSTCAUSE: rdata[`PMW_WRF_BIT] = wrf_q;
            `PMW_OFF_WAKEEN:   rdata[NP-1:0] = wakeEn_q;
            default:           hit = 1'b0;
        endcase
    end

    assign wrEn = psel && penable && pready_q && pwrite && !pslverr_q;

    always_comb begin
        sysClk_d      = sysClk_q;
        wdCtrl_d      = wdCtrl_q;
        mode_d        = mode_q;
        fastRcEn_d    = fastRcEn_q;
        pdf_d         = pdf_q;
        to_d          = to_q;
        wrf_d         = wrf_q;
        wakeEn_d      = wakeEn_q;
        subActive_d   = subActive_q;
        keepFast_d    = keepFast_q;
        keepSlow_d    = keepSlow_q;
        intBlock_d    = intBlock_q;
        divCnt_d      = divCnt_q + 6'h01;
        srstCnt_d     = 16'h0000;
        cpuRun_d      = cpuRun_q;
        wakeResume_d  = 1'b0;
        wakeService_d = 1'b0;
        pcSpReset_d   = 1'b0;
        deviceReset_d = 1'b0;
        wdClear       = 1'b0;
        prdata_d      = prdata_q;
        pready_d      = 1'b0;
        pslverr_d     = 1'b0;

        // One wait state: answer is built in the first access cycle
        if (psel && penable && !pready_q) begin
            pready_d  = 1'b1;
            pslverr_d = !hit;
            prdata_d  = hit ? rdata : 32'h0000_0000;
        end

        if (wrEn) begin
            case (paddr)
                `PMW_OFF_SYSCLK: begin
                    sysClk_d.div      = pwdata[7:`PMW_DIV_LSB];
                    sysClk_d.subSel   = pwdata[`PMW_SUBSEL_BIT];
                    sysClk_d.fastKeep = pwdata[`PMW_FASTKEEP_BIT];
                    sysClk_d.slowKeep = pwdata[`PMW_SLOWKEEP_BIT];
                end
                `PMW_OFF_FASTRC:   fastRcEn_d = pwdata[`PMW_FASTEN_BIT];
                `PMW_OFF_WDCTRL:   wdCtrl_d   = pwdata[7:0];
                `PMW_OFF_RSTCAUSE: if (!pwdata[`PMW_WRF_BIT]) wrf_d = 1'b0;
                `PMW_OFF_WAKEEN:   wakeEn_d   = pwdata[NP-1:0];
                default: ;
            endcase
        end

        // Clock source switching
        if (sysClk_q.div == `PMW_DIV_SUB) begin
            if (!subActive_q && subReady) begin
                subActive_d = 1'b1;
            end
        end else if (subActive_q && fastStable) begin
            subActive_d = 1'b0;
        end

        // CPU clock tick, gated while halted
        if (subActive_q) begin
            sysTick_d = cpuRun_q && subTick;
        end else begin
            sysTick_d = cpuRun_q && ((divCnt_q & divMask) == divMask);
        end

        if (cpuRun_q) begin
            mode_d      = subActive_d ? pmw_pkg::PMW_SLOW : pmw_pkg::PMW_FAST;
            fastOscEn_d = fastRcEn_d;
            subOscEn_d  = 1'b1;
            if (clrWdtReq) begin
                pdf_d   = 1'b0;
                wdClear = 1'b1;
            end
            if (wdOvf) begin
                to_d          = 1'b1;
                deviceReset_d = 1'b1;
            end else if (haltReq) begin
                // Registers, memory and ports are left untouched apart from pdf_q, to_q and the watchdog count; the CPU clock stops
                cpuRun_d   = 1'b0;
                keepFast_d = sysClk_q.fastKeep;
                keepSlow_d = sysClk_q.slowKeep;
                pdf_d      = 1'b1;
                to_d       = 1'b0;
                wdClear    = 1'b1;
                intBlock_d = intPending;
                case ({sysClk_q.fastKeep, sysClk_q.slowKeep})
                    2'b00:   mode_d = pmw_pkg::PMW_SLEEP;
                    2'b01:   mode_d = pmw_pkg::PMW_IDLE_SLOW;
                    2'b11:   mode_d = pmw_pkg::PMW_IDLE_BOTH;
                    default: mode_d = pmw_pkg::PMW_IDLE_FAST;
                endcase
                fastOscEn_d = fastRcEn_q && sysClk_q.fastKeep;
                subOscEn_d  = sysClk_q.slowKeep;
            end
        end else begin
            fastOscEn_d = fastRcEn_q && keepFast_q;
            subOscEn_d  = keepSlow_q;
            if (wdOvf) begin
                to_d        = 1'b1;
                pcSpReset_d = 1'b1;
                cpuRun_d    = 1'b1;
            end else if (intWake) begin
                cpuRun_d      = 1'b1;
                wakeService_d = intEnabled && !stackFull;
                wakeResume_d  = !(intEnabled && !stackFull);
            end else if (pinWake) begin
                cpuRun_d     = 1'b1;
                wakeResume_d = 1'b1;
            end
            if (cpuRun_d) begin
                mode_d      = subActive_q ? pmw_pkg::PMW_SLOW : pmw_pkg::PMW_FAST;
                fastOscEn_d = fastRcEn_q;
                subOscEn_d  = 1'b1;
            end
        end

        // Corrupted key: count the soft reset delay, then reset
        if (!keyOk) begin
            srstCnt_d = srstCnt_q + 16'h0001;
            if (srstCnt_q == 16'(SRESET_CYCLES - 1)) begin
                deviceReset_d = 1'b1;
                wrf_d         = 1'b1;
                wdCtrl_d      = `PMW_WDCTRL_RST;
                srstCnt_d     = 16'h0000;
            end
        end
        ioHold_d = !cpuRun_d;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sysClk_q      <= `PMW_SYSCLK_RST;
            wdCtrl_q      <= `PMW_WDCTRL_RST;
            mode_q        <= pmw_pkg::PMW_FAST;
            fastRcEn_q    <= `PMW_FASTRC_RST;
            pdf_q         <= 1'b0;
            to_q          <= 1'b0;
            wrf_q         <= 1'b0;
            wakeEn_q      <= `PMW_WAKEEN_RST;
            portPrev_q    <= '0;
            rcPrev_q      <= 1'b0;
            subPrev_q     <= 1'b0;
            subActive_q   <= 1'b0;
            keepFast_q    <= 1'b0;
            keepSlow_q    <= 1'b0;
            intBlock_q    <= '0;
            divCnt_q      <= 6'h00;
            srstCnt_q     <= 16'h0000;
            cpuRun_q      <= 1'b1;
            ioHold_q      <= 1'b0;
            sysTick_q     <= 1'b0;
            fastOscEn_q   <= 1'b1;
            subOscEn_q    <= 1'b1;
            wakeResume_q  <= 1'b0;
            wakeService_q <= 1'b0;
            pcSpReset_q   <= 1'b0;
            deviceReset_q <= 1'b0;
            prdata_q      <= 32'h0000_0000;
            pready_q      <= 1'b0;
            pslverr_q     <= 1'b0;
        end else begin
            sysClk_q      <= sysClk_d;
            wdCtrl_q      <= wdCtrl_d;
            mode_q        <= mode_d;
            fastRcEn_q    <= fastRcEn_d;
            pdf_q         <= pdf_d;
            to_q          <= to_d;
            wrf_q         <= wrf_d;
            wakeEn_q      <= wakeEn_d;
            portPrev_q    <= portNow;
            rcPrev_q      <= lircNow;
            subPrev_q     <= subNow;
            subActive_q   <= subActive_d;
            keepFast_q    <= keepFast_d;
            keepSlow_q    <= keepSlow_d;
            intBlock_q    <= intBlock_d;
            divCnt_q      <= divCnt_d;
            srstCnt_q     <= srstCnt_d;
            cpuRun_q      <= cpuRun_d;
            ioHold_q      <= ioHold_d;
            sysTick_q     <= sysTick_d;
            fastOscEn_q   <= fastOscEn_d;
            subOscEn_q    <= subOscEn_d;
            wakeResume_q  <= wakeResume_d;
            wakeService_q <= wakeService_d;
            pcSpReset_q   <= pcSpReset_d;
            deviceReset_q <= deviceReset_d;
            prdata_q      <= prdata_d;
            pready_q      <= pready_d;
            pslverr_q     <= pslverr_d;
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign cpuRun        = cpuRun_q;
    assign ioHold        = ioHold_q;
    assign sysTick       = sysTick_q;
    assign sysClkFromSub = subActive_q;
    assign fastOscEn     = fastOscEn_q;
    assign subOscEn      = subOscEn_q;
    assign opMode        = mode_q;
    assign wakeResume    = wakeResume_q;
    assign wakeService   = wakeService_q;
    assign pcSpReset     = pcSpReset_q;
    assign deviceReset   = deviceReset_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_halt_enters(logic fk, logic sk, pmw_pkg::pmw_mode_t m);
        cpuRun_q && haltReq && !wdOvf && sysClk_q.fastKeep == fk && sysClk_q.slowKeep == sk
        |=> opMode == m && !cpuRun_q;
    endproperty

    a_halt_sleep: assert property (p_halt_enters(1'b0, 1'b0, pmw_pkg::PMW_SLEEP))
        else $error("halt with no keep bits did not enter sleep");
    a_sleep_clocks: assert property (cpuRun_q && haltReq && !wdOvf && !sysClk_q.fastKeep
        && !sysClk_q.slowKeep |=> !fastOscEn && !subOscEn)
        else $error("sleep left an oscillator enabled");
    a_halt_idle_slow: assert property (p_halt_enters(1'b0, 1'b1, pmw_pkg::PMW_IDLE_SLOW))
        else $error("halt did not enter sub clock idle");
    a_halt_idle_both: assert property (p_halt_enters(1'b1, 1'b1, pmw_pkg::PMW_IDLE_BOTH))
        else $error("halt did not enter both clocks idle");
    a_halt_idle_fast: assert property (p_halt_enters(1'b1, 1'b0, pmw_pkg::PMW_IDLE_FAST))
        else $error("halt did not enter fast clock idle");
    a_halt_flags: assert property (cpuRun_q && haltReq && !wdOvf
        |=> pdf_q && !to_q && ioHold)
        else $error("halt did not set power-down and clear expiry");
    a_clear_pdf: assert property (cpuRun_q && clrWdtReq && !haltReq |=> !pdf_q)
        else $error("watchdog clear left power-down flag set");
    a_ovf_halted: assert property (!cpuRun_q && wdOvf
        |=> to_q && pcSpReset && cpuRun_q && !deviceReset)
        else $error("halted overflow mishandled");
    a_ovf_running: assert property (cpuRun_q && wdOvf |=> deviceReset && to_q)
        else $error("running overflow did not reset device");
    a_key_reset: assert property (!keyOk && srstCnt_q == 16'(SRESET_CYCLES - 1)
        |=> deviceReset && wrf_q && wdCtrl_q == `PMW_WDCTRL_RST)
        else $error("bad watchdog key did not reset after delay");
    a_sub_wait: assert property (!subActive_q && !subReady |=> !sysClkFromSub)
        else $error("switched to sub clock before it was stable");
    a_fast_wait: assert property (subActive_q && !fastStable |=> $stable(sysClkFromSub))
        else $error("left sub clock before fast oscillator stable");
    a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one wait state");

    c_sleep_entry: cover property (cpuRun_q && haltReq ##1 opMode == pmw_pkg::PMW_SLEEP);
    c_pin_wake:    cover property (!cpuRun_q && pinWake ##1 wakeResume);
    c_ovf_wake:    cover property (!cpuRun_q && wdOvf ##1 pcSpReset);
    c_key_reset:   cover property (!keyOk ##1 wrf_q);

endmodule

// ### rtl/pmw_watchdog.sv
// Watchdog divider counting low-speed RC ticks with selectable time-out
`timescale 1ns/1ps
`include "pmw_defines.svh"

module pmw_watchdog #(
    parameter int CW = 18
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       rcTick,
    input  wire logic       enable,
    input  wire logic       clear,
    input  wire logic [2:0] periodSel,
    output logic            overflow
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] term;
    logic          ovf_q;
    logic          ovf_d;
    logic          last;

    always_comb begin
        case (periodSel)
            3'h0:    term = CW'(18'h000FF);
            3'h1:    term = CW'(18'h003FF);
            3'h2:    term = CW'(18'h00FFF);
            3'h3:    term = CW'(18'h03FFF);
            3'h4:    term = CW'(18'h07FFF);
            3'h5:    term = CW'(18'h0FFFF);
            3'h6:    term = CW'(18'h1FFFF);
            default: term = CW'(18'h3FFFF);
        endcase
        last  = (cnt_q == term);
        cnt_d = cnt_q;
        ovf_d = 1'b0;
        if (clear) begin
            cnt_d = '0;
        end else if (enable && rcTick) begin
            cnt_d = last ? '0 : cnt_q + CW'(1);
            ovf_d = last;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    assign overflow = ovf_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_clear_zeroes: assert property (clear |=> cnt_q == '0)
        else $error("watchdog count not zero after clear");
    a_period_ovf: assert property (
        !clear && enable && rcTick && periodSel == 3'h0 && cnt_q == CW'(18'h000FF)
        |=> overflow && cnt_q == '0)
        else $error("watchdog shortest period overflow missed");

endmodule

// ### testbench/pmw_core_model.sv
// Core model issuing halt and clear-watchdog instruction pulses
`timescale 1ns/1ps
module pmw_core_model (
    input  wire logic clock,
    input  wire logic cpuRun,
    input  wire logic doHalt,
    input  wire logic doClr,
    output logic      haltReq = 1'b0,
    output logic      clrWdtReq = 1'b0
);
    // Instructions issue only while executing, one cycle each
    always @(posedge clock) begin
        haltReq <= doHalt & cpuRun;
        clrWdtReq <= doClr & cpuRun;
    end
endmodule

// ### testbench/tb.sv
// Testbench for the power-mode and watchdog block
`timescale 1ns/1ps
`include "pmw_defines.svh"
module tb;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, er, haltReq, clrWdtReq, cpuRun, ioHold, sysTick;
    logic        sysClkFromSub, fastOscEn, subOscEn, wakeResume, wakeService;
    logic        pcSpReset, deviceReset;
    logic        doHalt = 1'b0;
    logic        doClr = 1'b0;
    logic        intEnabled = 1'b0;
    logic [3:0]  intPending = 4'h0;
    logic [7:0]  portA = 8'hFF;
    logic [1:0]  lircDiv = 2'h0;
    logic        stackFull = 1'b0;
    logic        fastStb = 1'b1;
    logic        xtalStb = 1'b0;
    logic        rcStb = 1'b1;
    pmw_pkg::pmw_mode_t opMode;
    pmw_pkg::pmw_mode_t modes [4] = '{pmw_pkg::PMW_SLEEP, pmw_pkg::PMW_IDLE_SLOW,
                                      pmw_pkg::PMW_IDLE_FAST, pmw_pkg::PMW_IDLE_BOTH};
    int          failCount = 0;
    int          compares = 0;
    int          i, n;

    initial begin
        forever #20 clock = ~clock;
    end
    // RC tick every four cycles, sub clock every two
    always @(posedge clock) begin
        lircDiv <= lircDiv + 2'h1;
    end

    pmw_core_model core (.clock(clock), .cpuRun(cpuRun), .doHalt(doHalt), .doClr(doClr),
        .haltReq(haltReq), .clrWdtReq(clrWdtReq));
    pmw_power_mode_watchdog #(.SRESET_CYCLES(4)) dut (.clock(clock), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .haltReq(haltReq),
        .clrWdtReq(clrWdtReq), .intPending(intPending), .intEnabled(intEnabled),
        .stackFull(stackFull), .portA(portA), .lircClk(lircDiv[1]), .subClk(lircDiv[0]),
        .fastRcStable(fastStb), .subXtalStable(xtalStb), .subRcStable(rcStb), .cpuRun(cpuRun),
        .ioHold(ioHold), .sysTick(sysTick), .sysClkFromSub(sysClkFromSub),
        .fastOscEn(fastOscEn), .subOscEn(subOscEn), .opMode(opMode),
        .wakeResume(wakeResume), .wakeService(wakeService), .pcSpReset(pcSpReset),
        .deviceReset(deviceReset));

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Hold the request until pready is seen high at an edge; take the answer there
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task pulse(input logic h);
        @(posedge clock);
        if (h) doHalt <= 1'b1;
        else doClr <= 1'b1;
        @(posedge clock);
        doHalt <= 1'b0;
        doClr <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task waitFor(input logic rst, input int lim);
        n = 0;
        while ((rst ? deviceReset : cpuRun) !== 1'b1 && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    task print_verdict;
        $display("compares %0d fail_count %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #800000;
        failCount++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        rdc(`PMW_OFF_WDCTRL, 32'h53, "wdctrl");
        rdc(`PMW_OFF_STATUS, 32'h0, "status");
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        chk("unmappedData", 32'h0, rd);
        for (i = 0; i < 7; i++) begin
            apb(1'b1, `PMW_OFF_SYSCLK, i << `PMW_DIV_LSB);
            repeat (8) @(posedge clock);
            n = 0;
            repeat (128) begin
                @(posedge clock);
                #1;
                if (sysTick === 1'b1) n++;
            end
            chk("sysTick", 128 >> i, n);
        end
        // Crystal selected but not yet stable: the switch must wait
        apb(1'b1, `PMW_OFF_SYSCLK, 32'hE4);
        repeat (6) @(posedge clock);
        chk("subWait", 0, sysClkFromSub);
        xtalStb <= 1'b1;
        repeat (6) @(posedge clock);
        chk("toSub", 1, sysClkFromSub);
        fastStb <= 1'b0;
        apb(1'b1, `PMW_OFF_SYSCLK, 32'h0);
        repeat (6) @(posedge clock);
        chk("fastWait", 1, sysClkFromSub);
        rdc(`PMW_OFF_FASTRC, 32'h1, "fastFlag");
        fastStb <= 1'b1;
        repeat (6) @(posedge clock);
        chk("toFast", 0, sysClkFromSub);
        // Interrupt already pending at halt must never wake
        intPending[1] <= 1'b1;
        apb(1'b1, `PMW_OFF_WAKEEN, 32'h1);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `PMW_OFF_SYSCLK, i);
            intEnabled <= i[0];
            stackFull <= ~i[1];
            pulse(1'b1);
            rdc(`PMW_OFF_STATUS, 32'h1, "pdfSet");
            chk("halted", {2'b01, modes[i]}, {cpuRun, ioHold, opMode});
            chk("oscEn", {i[1], i[0]}, {fastOscEn, subOscEn});
            if (i[0]) intPending[0] <= 1'b1;
            else portA[0] <= 1'b0;
            waitFor(1'b0, 20);
            chk("wake", (i == 3) ? 2 : 1, {pcSpReset, wakeService, wakeResume});
            @(posedge clock);
            intPending[0] <= 1'b0;
            portA[0] <= 1'b1;
            pulse(1'b0);
            rdc(`PMW_OFF_STATUS, 32'h0, "pdfClr");
        end
        apb(1'b1, `PMW_OFF_WDCTRL, 32'h50);
        pulse(1'b1);
        waitFor(1'b0, 1100);
        chk("ovfTime", 1, n > 1000 && n < 1100);
        chk("ovfWake", 4, {pcSpReset, wakeService, wakeResume});
        rdc(`PMW_OFF_STATUS, 32'h3, "toSet");
        pulse(1'b0);
        waitFor(1'b1, 1100);
        chk("runOvf", 1, n > 1000 && n < 1100);
        rdc(`PMW_OFF_STATUS, 32'h2, "toRun");
        apb(1'b1, `PMW_OFF_WDCTRL, 32'hA8);
        waitFor(1'b1, 12);
        chk("keyAlt", 12, n);
        apb(1'b1, `PMW_OFF_WDCTRL, 32'h0);
        waitFor(1'b1, 20);
        chk("keyBad", 1, n < 20);
        rdc(`PMW_OFF_RSTCAUSE, 32'h1, "wrf");
        rdc(`PMW_OFF_WDCTRL, 32'h53, "reload");
        apb(1'b1, `PMW_OFF_RSTCAUSE, 32'h0);
        rdc(`PMW_OFF_RSTCAUSE, 32'h0, "wrfClr");
        print_verdict();
    end
endmodule
